// *** hw/cpc_pin_ctrl.sv ***
// Configuration sequencing, pin-function control and register slave
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cpc_pin_ctrl #(
  parameter int unsigned POR_LEN = cpc_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [cpc_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [cpc_pkg::AHB_DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [cpc_pkg::AHB_DW-1:0] hrdata,
  // Device pins, asynchronous
  input wire logic testShareSelect,
  input wire logic deviceClear_n,
  input wire logic deviceOutputEnable,
  input wire logic configRequest_n,
  input wire logic configStatusIn_n,
  output logic configStatusOut_n,
  output logic configStatusOe,
  output logic crcErrorOut,
  output logic crcErrorOe,
  // Configuration loader, same clock
  input wire logic loadDone,
  input wire logic loadError,
  input wire logic configMemoryBitsError,
  output logic loadStart,
  output logic loadReset,
  // Test port, same clock
  input wire logic testTdoDrive,
  input wire logic testTdoData,
  output logic tdoOut,
  output logic tdoOe,
  output logic tckOe,
  // User fabric controls
  input wire logic userTdoData,
  input wire logic userTdoOe,
  output logic testPinsUserIo,
  output logic shareSelectUserIo,
  output logic clearPinUserIo,
  output logic oePinUserIo,
  output logic statusPinUserIo,
  output logic requestUserPin,
  output logic requestUserLevel,
  output logic userRegClear,
  output logic ioTristate,
  output cpc_pkg::cpc_state_e cfgState
);
  import cpc_pkg::*;

  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinSync;
  logic shareSel;
  logic clrPin_n;
  logic oePin;
  logic reqPin_n;
  logic statPin_n;
  logic porDone;
  cpc_state_e state_q;
  cpc_state_e state_d;
  logic [4:0] ctrl_q;
  logic crcFlag_q;
  logic loadStart_q;
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addr_q;
  logic [AHB_DW-1:0] rdata_q;
  logic [AHB_DW-1:0] rdMux;
  logic addrPhase;
  logic crcClr;
  logic userMode;
  logic [1:0] ownPull_q;

  assign pinRaw = {configStatusIn_n, configRequest_n, deviceOutputEnable,
                   deviceClear_n, testShareSelect};

  cpc_sync #(
    .W(PIN_N),
    .INIT(5'h1f)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  cpc_por_timer #(
    .CYCLES(POR_LEN)
  ) u_por (
    .clk(clk),
    .rst_n(rst_n),
    .porDone(porDone)
  );

  assign shareSel = pinSync[0];
  assign clrPin_n = pinSync[1];
  assign oePin = pinSync[2];
  assign reqPin_n = pinSync[3];
  assign statPin_n = pinSync[4];
  assign userMode = (state_q == ST_USER);

  // Configuration sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POR: begin
        if (porDone) begin
          state_d = reqPin_n ? ST_CONFIG : ST_RESET;
        end
      end
      ST_RESET: begin
        if (reqPin_n) begin
          state_d = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (!reqPin_n) begin
          state_d = ST_RESET;
        end else if (loadError || (!statPin_n && !(|ownPull_q))) begin
          state_d = ST_ERROR;
        end else if (loadDone) begin
          state_d = ST_USER;
        end
      end
      ST_USER: begin
        if (!reqPin_n) begin
          state_d = ST_RESET;
        end
      end
      ST_ERROR: begin
        if (!reqPin_n) begin
          state_d = ST_RESET;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      ownPull_q <= '1;
    end else begin
      state_q <= state_d;
      ownPull_q <= {ownPull_q[0], configStatusOe};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loadStart_q <= 1'b0;
    end else begin
      loadStart_q <= (state_d == ST_CONFIG) && (state_q != ST_CONFIG);
    end
  end

  assign loadStart = loadStart_q;
  assign loadReset = (state_q == ST_RESET) || (state_q == ST_POR);
  assign cfgState = state_q;

  // Status pin: low in power-on, reset and error states
  assign configStatusOut_n = 1'b0;
  assign configStatusOe = (state_q == ST_POR) || (state_q == ST_RESET)
                          || (state_q == ST_ERROR);
  assign statusPinUserIo = userMode && ctrl_q[CTRL_STATIO];

  // Request pin becomes an input-only user pin
  assign requestUserPin = userMode;
  assign requestUserLevel = userMode && reqPin_n;

  // Test-port sharing, evaluated every cycle
  assign shareSelectUserIo = !ctrl_q[CTRL_SHARE];
  assign testPinsUserIo = userMode && ctrl_q[CTRL_SHARE] && !shareSel;
  assign tdoOut = testPinsUserIo ? userTdoData : testTdoData;
  assign tdoOe = testPinsUserIo ? (userTdoOe && !ioTristate) : testTdoDrive;
  assign tckOe = 1'b0;

  // Device-wide clear and output enable
  assign clearPinUserIo = !ctrl_q[CTRL_CLR];
  assign oePinUserIo = !ctrl_q[CTRL_OE];
  assign userRegClear = userMode && ctrl_q[CTRL_CLR] && !clrPin_n;
  assign ioTristate = !userMode || (ctrl_q[CTRL_OE] && !oePin);

  // CRC error flag, sticky, set wins over clear
  assign crcClr = wrPend_q && (addr_q == OFS_STAT) && hwdata[STAT_CRC];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crcFlag_q <= 1'b0;
    end else if (ctrl_q[CTRL_CRC] && configMemoryBitsError) begin
      crcFlag_q <= 1'b1;
    end else if (crcClr || !ctrl_q[CTRL_CRC]) begin
      crcFlag_q <= 1'b0;
    end
  end

  assign crcErrorOut = 1'b0;
  assign crcErrorOe = ctrl_q[CTRL_CRC] && !crcFlag_q;

  // AHB-Lite slave, zero wait states
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      rdPend_q <= addrPhase && !hwrite;
      addr_q <= addrPhase ? haddr[7:0] : addr_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrPend_q && (addr_q == OFS_CTRL)) begin
      ctrl_q <= hwdata[4:0];
    end
  end

  always_comb begin
    rdMux = '0;
    case (haddr[7:0])
      OFS_CTRL: rdMux[4:0] = ctrl_q;
      OFS_STAT: begin
        rdMux[2:0] = state_q;
        rdMux[STAT_CRC] = crcFlag_q;
        rdMux[STAT_PINS +: PIN_N] = pinSync;
      end
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (addrPhase && !hwrite) begin
      rdata_q <= rdMux;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_share_off;
    !ctrl_q[CTRL_SHARE] |-> !testPinsUserIo && shareSelectUserIo;
  endproperty
  a_share_off: assert property (p_share_off) else $error("share off gave user test pins");

  property p_share_low;
    userMode && ctrl_q[CTRL_SHARE] && !pinSync[0] |-> testPinsUserIo && (tdoOut == userTdoData);
  endproperty
  a_share_low: assert property (p_share_low) else $error("test pins not shared");

  property p_share_high;
    ctrl_q[CTRL_SHARE] && pinSync[0] |-> !testPinsUserIo && (tdoOe == testTdoDrive);
  endproperty
  a_share_high: assert property (p_share_high) else $error("test pins not dedicated");

  property p_crc_flag;
    ctrl_q[CTRL_CRC] && configMemoryBitsError |=> !crcErrorOe && crcFlag_q;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag not raised");

  property p_clear;
    userMode && ctrl_q[CTRL_CLR] && !pinSync[1] |-> userRegClear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not applied");

  property p_clear_user_only;
    userRegClear |-> userMode && ctrl_q[CTRL_CLR];
  endproperty
  a_clear_user_only: assert property (p_clear_user_only) else $error("clear outside user");

  property p_oe;
    ctrl_q[CTRL_OE] && !pinSync[2] |-> ioTristate && !(testPinsUserIo && tdoOe);
  endproperty
  a_oe: assert property (p_oe) else $error("io not tristated");

  property p_req_drop;
    userMode && !pinSync[3] |=> (state_q == ST_RESET) && ioTristate && loadReset;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request low ignored");

  property p_req_rise;
    (state_q == ST_RESET) && pinSync[3] |=> (state_q == ST_CONFIG) && loadStart;
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("no reconfiguration");

  property p_por_low;
    !porDone |-> configStatusOe && (state_q == ST_POR);
  endproperty
  a_por_low: assert property (p_por_low) else $error("status released early");

  property p_err_low;
    (state_q == ST_CONFIG) && pinSync[3] && (loadError || (!pinSync[4] && !(|ownPull_q)))
      |=> (state_q == ST_ERROR) && configStatusOe;
  endproperty
  a_err_low: assert property (p_err_low) else $error("error not signalled");

  property p_req_user;
    (state_q != ST_USER) |-> !requestUserPin && !requestUserLevel;
  endproperty
  a_req_user: assert property (p_req_user) else $error("request pin misused");

  property p_stat_dedicated;
    !ctrl_q[CTRL_STATIO] |-> !statusPinUserIo;
  endproperty
  a_stat_dedicated: assert property (p_stat_dedicated) else $error("status pin reassigned");

  property p_tck;
    !tckOe;
  endproperty
  a_tck: assert property (p_tck) else $error("test clock driven");

  c_user: cover property ((state_q == ST_CONFIG) ##1 (state_q == ST_USER));
  c_error: cover property ((state_q == ST_CONFIG) ##1 (state_q == ST_ERROR));
  c_shared: cover property (testPinsUserIo ##1 !testPinsUserIo);
  c_crc: cover property (!crcErrorOe && ctrl_q[CTRL_CRC]);
endmodule : cpc_pin_ctrl

// *** hw/cpc_pkg.sv ***
// Constants and types for the configuration pin control block
package cpc_pkg;
  localparam int unsigned AHB_AW = 32;
  localparam int unsigned AHB_DW = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int unsigned CTRL_SHARE = 0;
  localparam int unsigned CTRL_CRC = 1;
  localparam int unsigned CTRL_CLR = 2;
  localparam int unsigned CTRL_OE = 3;
  localparam int unsigned CTRL_STATIO = 4;
  localparam int unsigned STAT_CRC = 4;
  localparam int unsigned STAT_PINS = 8;
  localparam int unsigned PIN_N = 5;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned POR_TIME_NS = 100000;
  localparam int unsigned POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_POR,
    ST_RESET,
    ST_CONFIG,
    ST_USER,
    ST_ERROR
  } cpc_state_e;
endpackage : cpc_pkg

// *** hw/cpc_por_timer.sv ***
// Power-on reset interval counter
`timescale 1ns/1ps
module cpc_por_timer #(
  parameter int unsigned CYCLES = cpc_pkg::POR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Status
  output logic porDone
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;
  logic done_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q <= cnt_q + CW'(1);
      done_q <= (cnt_q == LAST);
    end
  end

  assign porDone = done_q;
endmodule : cpc_por_timer

// *** hw/cpc_sync.sv ***
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module cpc_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  assign pinOut = sync_q;
endmodule : cpc_sync

// *** verification/cpc_host_model.sv ***
// Host and loader model facing the configuration pin control block
`timescale 1ns/1ps
module cpc_host_model #(
  // Status filter window in cycles, above 5.5 ms at 40 ns
  parameter int unsigned FILT = 137501
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench commands
  input wire logic reqLow,
  input wire logic pullStatus,
  input wire logic [3:0] lat,
  // Device side
  input wire logic statusOe,
  input wire logic loadStart,
  output logic configRequest_n,
  output logic configStatusIn_n,
  output logic loadDone,
  output logic statusSeen_n
);
  localparam int unsigned FW = $clog2(FILT + 1);
  logic [FW-1:0] lowCnt_q;
  logic [3:0] cnt_q;
  logic busy_q;
  // Request held high from power-up
  assign configRequest_n = ~reqLow;
  // Status wire with pull-up, low if either party pulls
  assign configStatusIn_n = ~(statusOe | pullStatus);
  // Host sees status low only after FILT low cycles in a row
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_q <= '0;
      statusSeen_n <= 1'b1;
    end else if (configStatusIn_n) begin
      lowCnt_q <= '0;
      statusSeen_n <= 1'b1;
    end else if (lowCnt_q != FW'(FILT)) begin
      lowCnt_q <= lowCnt_q + FW'(1);
    end else begin
      statusSeen_n <= 1'b0;
    end
  end
  // Loader answers lat+1 cycles after it samples loadStart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      loadDone <= 1'b0;
    end else begin
      loadDone <= busy_q && (cnt_q == 4'h0) && !loadStart;
      if (loadStart) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        busy_q <= (cnt_q != 4'h0);
      end
    end
  end
endmodule : cpc_host_model

// *** verification/tb_top.sv ***
// Self-checking bench for the configuration pin control block
`timescale 1ns/1ps
module tb_top;
  import cpc_pkg::*;
  logic clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic testShareSelect;
  logic deviceClear_n;
  logic deviceOutputEnable;
  logic configRequest_n;
  logic configStatusIn_n;
  logic configStatusOe;
  logic crcErrorOe;
  logic loadDone;
  logic loadError;
  logic configMemoryBitsError;
  logic loadStart;
  logic tdoOut;
  logic tdoOe;
  logic tckOe;
  logic testTdoDrive;
  logic loadReset;
  logic requestUserLevel;
  logic configStatusOut_n;
  logic crcErrorOut;
  logic statusSeen_n;
  logic testPinsUserIo;
  logic shareSelectUserIo;
  logic clearPinUserIo;
  logic oePinUserIo;
  logic statusPinUserIo;
  logic requestUserPin;
  logic userRegClear;
  logic ioTristate;
  logic reqLow;
  logic pullStatus;
  logic [3:0] lat;
  cpc_state_e cfgState;
  int fails = 0;
  int checks_done = 0;
  int starts = 0;

  cpc_pin_ctrl #(.POR_LEN(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .testShareSelect(testShareSelect), .deviceClear_n(deviceClear_n),
    .deviceOutputEnable(deviceOutputEnable), .configRequest_n(configRequest_n),
    .configStatusIn_n(configStatusIn_n), .configStatusOut_n(configStatusOut_n),
    .configStatusOe(configStatusOe), .crcErrorOut(crcErrorOut), .crcErrorOe(crcErrorOe),
    .loadDone(loadDone), .loadError(loadError),
    .configMemoryBitsError(configMemoryBitsError), .loadStart(loadStart),
    .loadReset(loadReset), .testTdoDrive(testTdoDrive), .testTdoData(1'b0), .tdoOut(tdoOut),
    .tdoOe(tdoOe), .tckOe(tckOe), .userTdoData(1'b1), .userTdoOe(1'b1),
    .testPinsUserIo(testPinsUserIo), .shareSelectUserIo(shareSelectUserIo),
    .clearPinUserIo(clearPinUserIo), .oePinUserIo(oePinUserIo),
    .statusPinUserIo(statusPinUserIo), .requestUserPin(requestUserPin),
    .requestUserLevel(requestUserLevel), .userRegClear(userRegClear), .ioTristate(ioTristate),
    .cfgState(cfgState)
  );

  cpc_host_model #(.FILT(4)) i_host (
    .clk(clk), .rst_n(rst_n), .reqLow(reqLow), .pullStatus(pullStatus),
    .lat(lat), .statusOe(configStatusOe), .loadStart(loadStart),
    .configRequest_n(configRequest_n), .configStatusIn_n(configStatusIn_n),
    .loadDone(loadDone), .statusSeen_n(statusSeen_n)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (loadStart === 1'b1) starts <= starts + 1;
  end

  task finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task waitSt(input cpc_state_e s);
    while (cfgState !== s) cyc(1);
    cyc(1);
  endtask : waitSt

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 1'b0, "resp");
    #1;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e, input string m);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & k, e, m);
  endtask : rd

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    testShareSelect = 1'b0;
    testTdoDrive = 1'b0;
    deviceClear_n = 1'b1;
    deviceOutputEnable = 1'b1;
    loadError = 1'b0;
    configMemoryBitsError = 1'b0;
    reqLow = 1'b0;
    pullStatus = 1'b0;
    lat = 4'h1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk(configStatusOe, 1'b1, "por oe");
    chk(tckOe, 1'b0, "tck");
    chk(tdoOe, 1'b0, "tdo def");
    chk({configStatusOut_n, crcErrorOut}, 2'b00, "od low");
    chk(loadReset, 1'b1, "por rst");
    chk(statusSeen_n, 1'b1, "host filt");
    chk(requestUserPin, 1'b0, "req cfg");
    waitSt(ST_USER);
    chk(configStatusOe, 1'b0, "por end");
    chk(requestUserPin, 1'b1, "req user");
    chk(requestUserLevel, 1'b1, "req lvl");
    chk(statusPinUserIo, 1'b0, "stat ded");
    chk(starts, 1, "start");
    $display("test power-up done");
    rd(OFS_CTRL, 32'hffffffff, 32'h0, "ctrl rst");
    wr(8'h10, 32'h1f);
    rd(8'h10, 32'hffffffff, 32'h0, "unmapped");
    rd(OFS_STAT, 32'h7, 32'h3, "stat st");
    $display("test registers done");
    chk(testPinsUserIo, 1'b0, "sh off");
    chk(shareSelectUserIo, 1'b1, "sel io");
    wr(OFS_CTRL, 32'h1);
    chk(shareSelectUserIo, 1'b0, "sel pin");
    chk(testPinsUserIo, 1'b1, "sh low");
    chk(tdoOut, 1'b1, "tdo user");
    chk(tdoOe, 1'b1, "tdo user oe");
    testShareSelect <= 1'b1;
    testTdoDrive <= 1'b1;
    cyc(6);
    chk(testPinsUserIo, 1'b0, "sh high");
    chk(tdoOe, 1'b1, "tdo test oe");
    chk(tdoOut, 1'b0, "tdo test");
    $display("test sharing done");
    wr(OFS_CTRL, 32'h0);
    deviceClear_n <= 1'b0;
    deviceOutputEnable <= 1'b0;
    cyc(6);
    chk({userRegClear, ioTristate}, 2'b00, "feat off");
    chk({clearPinUserIo, oePinUserIo}, 2'b11, "pins io");
    wr(OFS_CTRL, 32'h1e);
    chk(userRegClear, 1'b1, "clear");
    chk(ioTristate, 1'b1, "oe low");
    chk(statusPinUserIo, 1'b1, "stat io");
    deviceClear_n <= 1'b1;
    deviceOutputEnable <= 1'b1;
    cyc(6);
    chk({userRegClear, ioTristate}, 2'b00, "pins hi");
    $display("test overrides done");
    chk(crcErrorOe, 1'b1, "crc ok");
    configMemoryBitsError <= 1'b1;
    cyc(1);
    configMemoryBitsError <= 1'b0;
    cyc(2);
    chk(crcErrorOe, 1'b0, "crc err");
    rd(OFS_STAT, 32'h10, 32'h10, "crc flag");
    $display("test crc done");
    lat <= 4'hf;
    reqLow <= 1'b1;
    waitSt(ST_RESET);
    chk({ioTristate, configStatusOe}, 2'b11, "req low");
    chk(loadReset, 1'b1, "ld rst");
    deviceClear_n <= 1'b0;
    reqLow <= 1'b0;
    waitSt(ST_CONFIG);
    chk(userRegClear, 1'b0, "clr prog");
    pullStatus <= 1'b1;
    waitSt(ST_ERROR);
    chk(configStatusOe, 1'b1, "forced");
    cyc(6);
    chk(statusSeen_n, 1'b0, "host seen");
    pullStatus <= 1'b0;
    deviceClear_n <= 1'b1;
    reqLow <= 1'b1;
    waitSt(ST_RESET);
    reqLow <= 1'b0;
    waitSt(ST_CONFIG);
    loadError <= 1'b1;
    cyc(1);
    loadError <= 1'b0;
    waitSt(ST_ERROR);
    chk(configStatusOe, 1'b1, "load err");
    lat <= 4'h0;
    reqLow <= 1'b1;
    waitSt(ST_RESET);
    reqLow <= 1'b0;
    waitSt(ST_USER);
    chk(starts, 4, "restarts");
    chk(configStatusOe, 1'b0, "user");
    chk(loadReset, 1'b0, "ld run");
    chk(statusSeen_n, 1'b1, "host ok");
    $display("test reconfig done");
    finish_test;
  end
endmodule : tb_top
